// file: hdl/tx_level_and_rx_gain_control.sv
// Transmit output level control, line driver enable and receive gain control top.
// Assumes a synchronous core register port and asynchronous symbol clock and comparator pins.
//
// Summary of operation
// - Fixed-mode bit set: apply the register's 3-bit attenuation, no automatic changes.
// - Attenuation code selects eight levels, 0 dB to 21 dB in 3 dB steps.
// - Fixed-mode bit clear: attenuation follows the peak measured on the sense input.
// - Peak below low threshold raises level a step; above high lowers it.
// - Each level iteration takes two symbol periods: evaluate, then apply.
// - Level adjusts only during the first 16 symbol ticks of transmit.
// - Reset sets automatic level to minimum, the maximum attenuation.
// - Receive mode retains the automatic level for the next transmission.
// - Line driver enable is driven low while transmitting.
// - After transmit ends, driver enable stays low for a short hold.
// - Receive blocks are off while transmitting; the shared low-pass stays on.
// - Low-pass cutoff selectable between 130 kHz and 195 kHz.
// - Receive gain has eight settings, 0 dB to -42 dB, chosen by the loop.
// - Gain loop measures converter level and keeps its average in a window.
// - Gain iteration spans two symbol ticks: measure, then update.
// - Symbol clock runs at eight times the channel bit rate.
// - Transmit select high means transmit, low means receive.
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module tx_level_and_rx_gain_control #(
    parameter int SAMPLE_W = level_gain_pkg::SAMPLE_W,
    parameter int HOLD_CYCLES = level_gain_pkg::DRIVER_HOLD_CYCLES
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register port
    input wire logic [level_gain_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [level_gain_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [level_gain_pkg::DATA_W-1:0] reg_rdata,
    // Asynchronous pins
    input wire logic symbol_clk,
    input wire logic level_below_low,
    input wire logic level_above_high,
    // Converter samples
    input wire logic signed [SAMPLE_W-1:0] adc_sample,
    input wire logic adc_sample_valid,
    // Analogue controls
    output logic [2:0] tx_atten_code,
    output logic [2:0] rx_gain_code,
    output logic rx_blocks_enable,
    output logic lowpass_enable,
    output logic lowpass_wide,
    // Open-drain driver enable
    output logic line_driver_enable_n_out,
    output logic line_driver_enable_n_oe
);
    localparam int HCW = $clog2(HOLD_CYCLES + 1);
    localparam logic [HCW-1:0] HOLD_LOAD = HCW'(HOLD_CYCLES);

    logic [3:0] level_ctrl_r;
    logic [2:0] mode_r;
    logic [15:0] window_r;
    logic [2:0] sym_sync_r;
    logic [1:0] below_sync_r;
    logic [1:0] above_sync_r;
    logic tick;
    logic tx_r;
    logic tx_prev_r;
    logic fixed_mode;
    logic [2:0] fixed_code;
    level_gain_pkg::alc_state_t alc_r;
    logic [4:0] tick_cnt_r;
    logic up_r;
    logic down_r;
    logic [2:0] auto_atten_r;
    logic [HCW-1:0] hold_cnt_r;
    logic [2:0] gain_code;

    assign tx_r = mode_r[level_gain_pkg::TX_SELECT_BIT];
    assign fixed_mode = level_ctrl_r[level_gain_pkg::FIXED_BIT];
    assign fixed_code = level_ctrl_r[2:0];
    assign tick = sym_sync_r[1] & ~sym_sync_r[2];

    // Register writes
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            level_ctrl_r <= level_gain_pkg::LEVEL_CTRL_RESET;
            mode_r <= level_gain_pkg::MODE_CTRL_RESET;
            window_r <= level_gain_pkg::AGC_WINDOW_RESET;
        end
        else if (reg_write)
        begin
            unique case (reg_addr)
                level_gain_pkg::LEVEL_CTRL_ADDR: level_ctrl_r <= reg_wdata[3:0];
                level_gain_pkg::MODE_CTRL_ADDR: mode_r <= reg_wdata[2:0];
                level_gain_pkg::AGC_WINDOW_ADDR: window_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Register reads, answer in the following cycle; unmapped reads return zero
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            reg_rdata <= '0;
        else if (reg_read)
        begin
            unique case (reg_addr)
                level_gain_pkg::LEVEL_CTRL_ADDR: reg_rdata <= {12'h000, level_ctrl_r};
                level_gain_pkg::MODE_CTRL_ADDR: reg_rdata <= {13'h0, mode_r};
                level_gain_pkg::STATUS_ADDR:
                    reg_rdata <= {1'b0, line_driver_enable_n_oe, alc_r, tick_cnt_r,
                                  gain_code, 1'b0, auto_atten_r};
                level_gain_pkg::AGC_WINDOW_ADDR: reg_rdata <= window_r;
                default: reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end

    // Pin synchronisers; comparators are looked at on the second stage, the symbol edge on the second and third
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sym_sync_r <= 3'h0;
            below_sync_r <= 2'h0;
            above_sync_r <= 2'h0;
        end
        else
        begin
            sym_sync_r <= {sym_sync_r[1:0], symbol_clk};
            below_sync_r <= {below_sync_r[0], level_below_low};
            above_sync_r <= {above_sync_r[0], level_above_high};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            tx_prev_r <= 1'b0;
        else
            tx_prev_r <= tx_r;
    end

    // Level loop sequencer; the window restarts on every entry into transmit
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            alc_r <= level_gain_pkg::ALC_IDLE;
            tick_cnt_r <= 5'h00;
            up_r <= 1'b0;
            down_r <= 1'b0;
        end
        else if (!tx_r)
        begin
            alc_r <= level_gain_pkg::ALC_IDLE;
            tick_cnt_r <= 5'h00;
        end
        else if (!tx_prev_r)
        begin
            alc_r <= level_gain_pkg::ALC_EVAL;
            tick_cnt_r <= 5'h00;
        end
        else if (tick && alc_r != level_gain_pkg::ALC_FROZEN && alc_r != level_gain_pkg::ALC_IDLE)
        begin
            tick_cnt_r <= tick_cnt_r + 5'h01;
            if (alc_r == level_gain_pkg::ALC_EVAL)
            begin
                up_r <= below_sync_r[1];
                down_r <= above_sync_r[1] & ~below_sync_r[1];
            end
            if (tick_cnt_r == level_gain_pkg::ADJUST_TICKS - 5'h01)
                alc_r <= level_gain_pkg::ALC_FROZEN;
            else if (alc_r == level_gain_pkg::ALC_EVAL)
                alc_r <= level_gain_pkg::ALC_APPLY;
            else
                alc_r <= level_gain_pkg::ALC_EVAL;
        end
    end

    // Automatic attenuation; kept across receive periods
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            auto_atten_r <= level_gain_pkg::CODE_MAX;
        else if (tick && tx_r && tx_prev_r && !fixed_mode
                 && alc_r == level_gain_pkg::ALC_APPLY)
        begin
            if (up_r && auto_atten_r != level_gain_pkg::CODE_MIN)
                auto_atten_r <= auto_atten_r - 3'h1;
            else if (down_r && auto_atten_r != level_gain_pkg::CODE_MAX)
                auto_atten_r <= auto_atten_r + 3'h1;
        end
    end

    // Code n means n times 3 dB of attenuation
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            tx_atten_code <= level_gain_pkg::CODE_MAX;
        else if (fixed_mode)
            tx_atten_code <= fixed_code;
        else
            tx_atten_code <= auto_atten_r;
    end

    // Driver enable with hold after transmit ends
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            hold_cnt_r <= '0;
        else if (tx_r)
            hold_cnt_r <= HOLD_LOAD;
        else if (hold_cnt_r != '0)
            hold_cnt_r <= hold_cnt_r - HCW'(1);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            line_driver_enable_n_out <= 1'b1;
            line_driver_enable_n_oe <= 1'b0;
        end
        else
        begin
            // Open drain: only ever pull low, the pull-up gives the high level
            line_driver_enable_n_out <= ~(tx_r || hold_cnt_r != '0);
            line_driver_enable_n_oe <= tx_r || hold_cnt_r != '0;
        end
    end

    // Receive path power and shared filter controls
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rx_blocks_enable <= 1'b0;
            lowpass_enable <= 1'b0;
            lowpass_wide <= 1'b0;
            rx_gain_code <= level_gain_pkg::CODE_MIN;
        end
        else
        begin
            rx_blocks_enable <= ~tx_r;
            lowpass_enable <= 1'b1;
            lowpass_wide <= mode_r[level_gain_pkg::LPF_WIDE_BIT];
            rx_gain_code <= gain_code;
        end
    end

    gain_step_if #(.SAMPLE_W(SAMPLE_W)) gsi ();
    assign gsi.tick = tick;
    assign gsi.run = ~tx_r & mode_r[level_gain_pkg::AGC_ENABLE_BIT];
    assign gsi.sample = adc_sample;
    assign gsi.sample_valid = adc_sample_valid;
    assign gsi.win_low = window_r[7:0];
    assign gsi.win_high = window_r[15:8];
    assign gain_code = gsi.gain_code;

    auto_gain_loop #(.SAMPLE_W(SAMPLE_W)) u_gain (
        .sys_clk(sys_clk),
        .reset(reset),
        .gl(gsi.loop)
    );

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_fixed_code_out: assert property ($past(fixed_mode) |-> tx_atten_code == $past(fixed_code))
        else $error("fixed attenuation not applied");
    a_auto_code_out: assert property ($past(!fixed_mode) |-> tx_atten_code == $past(auto_atten_r))
        else $error("automatic attenuation not applied");
    a_auto_one_step: assert property (auto_atten_r != $past(auto_atten_r) |->
        auto_atten_r == $past(auto_atten_r) + 3'h1 || auto_atten_r == $past(auto_atten_r) - 3'h1)
        else $error("level moved more than one step");
    a_apply_phase_only: assert property (auto_atten_r != $past(auto_atten_r) |->
        $past(alc_r) == level_gain_pkg::ALC_APPLY && $past(tick))
        else $error("level changed outside an apply tick");
    a_window_bound: assert property (tick_cnt_r <= level_gain_pkg::ADJUST_TICKS)
        else $error("adjustment ran past sixteen ticks");
    a_reset_level: assert property ($past(reset) |-> auto_atten_r == level_gain_pkg::CODE_MAX)
        else $error("level not at maximum attenuation after reset");
    a_retain_level: assert property (!tx_r && $past(!tx_r) |-> $stable(auto_atten_r))
        else $error("level changed while receiving");
    a_driver_on_tx: assert property ($past(tx_r) |-> line_driver_enable_n_oe && !line_driver_enable_n_out)
        else $error("driver enable not low while transmitting");
    // Hold length is a parameter, so the hold is checked through its counter
    a_driver_hold: assert property (!tx_r && hold_cnt_r != '0 |=> line_driver_enable_n_oe)
        else $error("driver enable released without hold");
    a_hold_reload: assert property (!$past(reset) && $fell(tx_r) |-> hold_cnt_r == HOLD_LOAD)
        else $error("driver hold not started at full length");
    a_rx_off_tx: assert property ($past(tx_r) |-> !rx_blocks_enable && lowpass_enable)
        else $error("receive blocks active while transmitting");
    a_no_wrap: assert property (!($past(auto_atten_r) == level_gain_pkg::CODE_MAX
        && auto_atten_r == level_gain_pkg::CODE_MIN))
        else $error("attenuation wrapped");

    c_frozen: cover property (alc_r == level_gain_pkg::ALC_FROZEN);
    c_level_step: cover property (auto_atten_r != $past(auto_atten_r));
    c_hold_release: cover property ($fell(line_driver_enable_n_oe));
    c_fixed_tx: cover property (fixed_mode && tx_r);
endmodule : tx_level_and_rx_gain_control

// file: hdl/level_gain_pkg.sv
// Constants, register map and state types for the transmit level and receive gain control.
// Assumes a single 125 MHz clock and a plain strobe register port.
package level_gain_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int SAMPLE_W = 12;
    // Register offsets
    localparam logic [3:0] LEVEL_CTRL_ADDR = 4'h0;
    localparam logic [3:0] MODE_CTRL_ADDR = 4'h1;
    localparam logic [3:0] STATUS_ADDR = 4'h2;
    localparam logic [3:0] AGC_WINDOW_ADDR = 4'h3;
    // Field positions
    localparam int FIXED_BIT = 3;
    localparam int TX_SELECT_BIT = 0;
    localparam int LPF_WIDE_BIT = 1;
    localparam int AGC_ENABLE_BIT = 2;
    // Reset values
    localparam logic [3:0] LEVEL_CTRL_RESET = 4'h0;
    localparam logic [2:0] MODE_CTRL_RESET = 3'h4;
    localparam logic [15:0] AGC_WINDOW_RESET = 16'h5030;
    // Attenuation and gain codes: 3 dB per attenuation step, 6 dB per gain step
    localparam logic [2:0] CODE_MIN = 3'h0;
    localparam logic [2:0] CODE_MAX = 3'h7;
    localparam int ATTEN_STEP_DB = 3;
    localparam int GAIN_STEP_DB = 6;
    // Timing
    localparam logic [4:0] ADJUST_TICKS = 5'h10;
    localparam int SYMBOL_PER_BIT = 8;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int DRIVER_HOLD_NS = 1000;
    localparam int DRIVER_HOLD_CYCLES = (DRIVER_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int AVG_SHIFT = 4;

    typedef enum logic [1:0] {
        ALC_IDLE = 2'b00,
        ALC_EVAL = 2'b01,
        ALC_APPLY = 2'b10,
        ALC_FROZEN = 2'b11
    } alc_state_t;

    typedef enum logic {
        AGC_MEASURE = 1'b0,
        AGC_UPDATE = 1'b1
    } agc_phase_t;
endpackage : level_gain_pkg

// file: hdl/gain_step_if.sv
// Carrier between the control top and the receive gain loop.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface gain_step_if #(parameter int SAMPLE_W = 12);
    logic tick;
    logic run;
    logic signed [SAMPLE_W-1:0] sample;
    logic sample_valid;
    logic [7:0] win_low;
    logic [7:0] win_high;
    logic [2:0] gain_code;
    modport loop (input tick, run, sample, sample_valid, win_low, win_high, output gain_code);
    modport ctrl (output tick, run, sample, sample_valid, win_low, win_high, input gain_code);
endinterface : gain_step_if

// file: hdl/auto_gain_loop.sv
// Digital receive gain loop: averages converter magnitude and steps the gain code.
// Assumes samples and symbol ticks arrive synchronous to sys_clk.
`timescale 1ns/1ps
module auto_gain_loop #(parameter int SAMPLE_W = 12)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Loop carrier
    gain_step_if.loop gl
);
    localparam int AW = SAMPLE_W;
    logic [AW-1:0] mag;
    logic [AW-1:0] avg_r;
    logic signed [AW:0] diff;
    level_gain_pkg::agc_phase_t phase_r;
    logic up_r;
    logic down_r;
    logic [2:0] gain_r;

    always_comb
    begin
        mag = gl.sample[SAMPLE_W-1] ? AW'(-gl.sample) : AW'(gl.sample);
        diff = $signed({1'b0, mag}) - $signed({1'b0, avg_r});
    end

    // Leaky average keeps the window test free of a divider
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            avg_r <= '0;
        else if (gl.sample_valid)
            avg_r <= AW'($signed({1'b0, avg_r}) + (diff >>> level_gain_pkg::AVG_SHIFT));
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            phase_r <= level_gain_pkg::AGC_MEASURE;
            up_r <= 1'b0;
            down_r <= 1'b0;
            gain_r <= level_gain_pkg::CODE_MIN;
        end
        else if (!gl.run)
            phase_r <= level_gain_pkg::AGC_MEASURE;
        else if (gl.tick)
        begin
            unique case (phase_r)
                level_gain_pkg::AGC_MEASURE:
                begin
                    up_r <= avg_r[AW-1 -: 8] > gl.win_high;
                    down_r <= avg_r[AW-1 -: 8] < gl.win_low;
                    phase_r <= level_gain_pkg::AGC_UPDATE;
                end
                level_gain_pkg::AGC_UPDATE:
                begin
                    // Larger code means more receive attenuation, 0 dB to -42 dB
                    if (up_r && gain_r != level_gain_pkg::CODE_MAX)
                        gain_r <= gain_r + 3'h1;
                    else if (down_r && gain_r != level_gain_pkg::CODE_MIN)
                        gain_r <= gain_r - 3'h1;
                    phase_r <= level_gain_pkg::AGC_MEASURE;
                end
            endcase
        end
    end

    assign gl.gain_code = gain_r;

    a_gain_on_update: assert property (@(posedge sys_clk) disable iff (reset)
        gain_r != $past(gain_r) |-> $past(phase_r) == level_gain_pkg::AGC_UPDATE && $past(gl.tick))
        else $error("receive gain changed outside an update tick");
    a_gain_single_step: assert property (@(posedge sys_clk) disable iff (reset)
        gain_r == $past(gain_r) || gain_r == $past(gain_r) + 3'h1 || gain_r == $past(gain_r) - 3'h1)
        else $error("receive gain jumped more than one step");
    c_gain_change: cover property (@(posedge sys_clk) disable iff (reset)
        gain_r != $past(gain_r));
endmodule : auto_gain_loop

// file: tb/line_side_model.sv
// Far-side model: line driver with pulled-up enable pin, peak detector and line coupler.
// Assumes it sees the block's analogue control outputs and shares sys_clk.
`timescale 1ns/1ps
module line_side_model
(
    // Clock
    input wire logic sys_clk,
    // Controls from the block
    input wire logic [2:0] tx_atten_code,
    input wire logic [2:0] rx_gain_code,
    input wire logic line_driver_enable_n_out,
    input wire logic line_driver_enable_n_oe,
    input wire logic signed [7:0] peak_offset,
    // Resolved pin and sensed levels
    output logic line_pin,
    output logic level_below_low,
    output logic level_above_high,
    output logic signed [11:0] adc_sample,
    output logic adc_sample_valid
);
    int peak;
    logic phase_r = 1'b0;
    logic signed [11:0] amp;
    // External pull-up: the pin is low only while the block pulls it
    assign line_pin = (line_driver_enable_n_oe && !line_driver_enable_n_out) ? 1'b0 : 1'b1;
    // Peak on the sense input drops 3 per attenuation step; thresholds at 9 and 12
    assign peak = 21 - 3 * int'(tx_atten_code) + int'(peak_offset);
    assign level_below_low = peak < 9;
    assign level_above_high = peak > 12;
    // Square wave of 2000 counts, halved per receive gain step
    assign amp = 12'sh7D0 >>> rx_gain_code;
    assign adc_sample = phase_r ? amp : -amp;
    assign adc_sample_valid = 1'b1;
    always_ff @(posedge sys_clk)
    begin
        phase_r <= !phase_r;
    end
endmodule : line_side_model

// file: tb/tx_level_and_rx_gain_control_tb_top.sv
// Self-checking bench for the transmit level and receive gain control block.
// Assumes the line side model on the pins and a free-running symbol clock.
`timescale 1ns/1ps
module tx_level_and_rx_gain_control_tb_top;
    // Short driver hold keeps the release check quick
    localparam int HOLD = 4;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic symbol_clk = 1'b0;
    logic signed [7:0] peak_offset = 8'sh00;
    logic level_below_low;
    logic level_above_high;
    logic signed [11:0] adc_sample;
    logic adc_sample_valid;
    logic [2:0] tx_atten_code;
    logic [2:0] rx_gain_code;
    logic rx_blocks_enable;
    logic lowpass_enable;
    logic lowpass_wide;
    logic drv_out;
    logic drv_oe;
    logic line_pin;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;

    always #4 sys_clk = ~sys_clk;
    // Symbol clock rises on a sys_clk rising edge, 25 cycles per tick
    always #100 symbol_clk = ~symbol_clk;

    tx_level_and_rx_gain_control #(.HOLD_CYCLES(HOLD)) dut (.sys_clk(sys_clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .symbol_clk(symbol_clk), .level_below_low(level_below_low),
        .level_above_high(level_above_high), .adc_sample(adc_sample),
        .adc_sample_valid(adc_sample_valid), .tx_atten_code(tx_atten_code),
        .rx_gain_code(rx_gain_code), .rx_blocks_enable(rx_blocks_enable),
        .lowpass_enable(lowpass_enable), .lowpass_wide(lowpass_wide),
        .line_driver_enable_n_out(drv_out), .line_driver_enable_n_oe(drv_oe));

    line_side_model far (.sys_clk(sys_clk), .tx_atten_code(tx_atten_code),
        .rx_gain_code(rx_gain_code), .line_driver_enable_n_out(drv_out),
        .line_driver_enable_n_oe(drv_oe), .peak_offset(peak_offset), .line_pin(line_pin),
        .level_below_low(level_below_low), .level_above_high(level_above_high),
        .adc_sample(adc_sample), .adc_sample_valid(adc_sample_valid));

    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_fail++;
            $display("MISMATCH at %0t: run did not finish", $time);
            results();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    task automatic ticks(input int n);
        repeat (n) @(posedge symbol_clk);
        cyc(8);
    endtask : ticks

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        check(reg_rdata, exp, "read data");
        @(posedge sys_clk);
    endtask : reg_rd

    task automatic t_reset();
        check(16'(tx_atten_code), 16'h0007, "reset attenuation");
        check(16'(rx_blocks_enable), 16'h0001, "receive blocks on");
        check(16'(lowpass_enable), 16'h0001, "low-pass on");
        check(16'(line_pin), 16'h0001, "driver pin idle");
        reg_rd(4'h0, 16'h0000);
        reg_rd(4'h1, 16'h0004);
        reg_rd(4'h3, 16'h5030);
        reg_wr(4'hF, 16'hFFFF);
        reg_rd(4'hF, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_gain();
        ticks(12);
        check(16'(rx_gain_code), 16'h0001, "receive gain settled");
        reg_wr(4'h1, 16'h0006);
        cyc(2);
        check(16'(lowpass_wide), 16'h0001, "wide cutoff");
        reg_wr(4'h1, 16'h0004);
        cyc(2);
        check(16'(lowpass_wide), 16'h0000, "narrow cutoff");
        $display("test gain and cutoff done");
    endtask : t_gain

    // One transmission under automatic level control, then back to receive
    task automatic t_auto(input logic signed [7:0] off, input logic [2:0] exp);
        peak_offset <= off;
        reg_wr(4'h1, 16'h0005);
        cyc(3);
        check(16'(line_pin), 16'h0000, "driver on in transmit");
        check(16'(rx_blocks_enable), 16'h0000, "receive blocks off");
        check(16'(lowpass_enable), 16'h0001, "low-pass kept on");
        ticks(20);
        check(16'(tx_atten_code), 16'(exp), "automatic level");
        peak_offset <= (exp == 3'h0) ? 8'sh1E : -8'sh1E;
        ticks(6);
        check(16'(tx_atten_code), 16'(exp), "level frozen");
        reg_wr(4'h1, 16'h0004);
        cyc(2);
        check(16'(line_pin), 16'h0000, "driver held after transmit");
        cyc(HOLD + 4);
        check(16'(line_pin), 16'h0001, "driver released");
        check(16'(rx_blocks_enable), 16'h0001, "receive blocks back on");
        ticks(4);
        check(16'(tx_atten_code), 16'(exp), "level kept in receive");
        // Status: driver released, loop idle, receive gain one step, kept level
        reg_rd(4'h2, 16'h0010 | 16'(exp));
        $display("test automatic level %0d done", exp);
    endtask : t_auto

    task automatic t_fixed();
        for (int c = 0; c < 8; c++)
        begin
            reg_wr(4'h0, 16'hFFF8 | 16'(c));
            reg_rd(4'h0, 16'h0008 | 16'(c));
            check(16'(tx_atten_code), 16'(c), "fixed attenuation");
        end
        // Fixed mode during a transmit that would otherwise raise the level
        reg_wr(4'h0, 16'h000A);
        // Let an edge pass so the write strobe is not reassigned in one step
        cyc(1);
        peak_offset <= -8'sh1E;
        reg_wr(4'h1, 16'h0005);
        ticks(20);
        check(16'(tx_atten_code), 16'h0002, "fixed in transmit");
        reg_wr(4'h0, 16'h0000);
        cyc(3);
        check(16'(tx_atten_code), 16'h0007, "automatic level untouched");
        reg_wr(4'h1, 16'h0004);
        $display("test fixed level done");
    endtask : t_fixed

    initial
    begin
        cyc(16);
        reset <= 1'b0;
        cyc(2);
        t_reset();
        t_gain();
        t_auto(8'sh00, 3'h4);
        t_auto(-8'sh1E, 3'h0);
        t_auto(8'sh0C, 3'h7);
        t_fixed();
        results();
    end
endmodule : tx_level_and_rx_gain_control_tb_top
